// >>> rtl/video_port_tristate_and_cal_gate.sv
// Video port tri-state control and gated pixel offset calibration registers
`timescale 1ns/100ps

// Contract
// - Global bit tri-states all video outputs
// - Keep bits win over global tri-state
// - Bit 3 keeps vsync driven, master mode
// - Bit 2 keeps hsync driven, master mode
// - Bit 1 keeps pixel clock driven, master
// - Bit 0 keeps external sync driven, master
// - Code 5 switches calibration circuits on
// - Calibration register reachable only at code 01
// - Access code 1 opens, 0 closes
module video_port_tristate_and_cal_gate
	import vidport_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Classic Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [WB_AW-1:0]  wb_adr_i,
	input  wire logic [WB_SW-1:0]  wb_sel_i,
	input  wire logic [WB_DW-1:0]  wb_dat_i,
	output logic      [WB_DW-1:0]  wb_dat_o,
	output logic                   wb_ack_o,
	// Sensor timing state and internal video sources, same clock
	input  wire logic              master_mode,
	input  wire logic              vsync_src,
	input  wire logic              hsync_src,
	input  wire logic              pclk_src,
	input  wire logic              extsync_src,
	input  wire logic [DATA_W-1:0] data_src,
	// Digital video port pads
	output logic                   vsync_out,
	output logic                   vsync_oe,
	output logic                   hsync_out,
	output logic                   hsync_oe,
	output logic                   pclk_out,
	output logic                   pclk_oe,
	output logic                   extsync_out,
	output logic                   extsync_oe,
	output logic      [DATA_W-1:0] data_out,
	output logic                   data_oe,
	// Calibration circuit control
	output logic                   cal_circuit_en,
	output logic                   init_regs_open
);

	typedef struct packed {
		bus_phase_t       phase;
		logic             ack;
		logic [7:0]       rdat;
		logic [TRI_W-1:0] tri_ctrl;
		logic [7:0]       cal_code;
		logic [7:0]       init_code;
		logic             cal_on;
		logic             init_open;
	} bank_state_t;

	bank_state_t st_r;
	bank_state_t st_nxt;

	pad_if pads ();

	logic [7:0] word_idx;
	logic       req;
	logic       wr_byte;
	logic       hit_tri;
	logic       hit_cal;
	logic       hit_init;
	logic       gate_open;

	// Word index from the byte address; the low two address bits are ignored
	assign word_idx  = wb_adr_i[9:2];
	assign req       = wb_cyc_i & wb_stb_i;
	assign wr_byte   = wb_we_i & wb_sel_i[0];
	assign hit_tri   = (word_idx == REG_IDX_TRISTATE);
	assign hit_cal   = (word_idx == REG_IDX_CAL);
	assign hit_init  = (word_idx == REG_IDX_INIT);
	// Gate follows the stored access code, so the write that opens it takes
	// effect only for the following access
	assign gate_open = (st_r.init_code == INIT_OPEN_CODE);

	always_comb begin
		st_nxt = st_r;
		case (st_r.phase)
			BUS_IDLE: begin
				st_nxt.ack = 1'b0;
				if (req) begin
					st_nxt.phase = BUS_ACK;
					st_nxt.ack   = 1'b1;
					// Unmapped words and a closed calibration register read zero
					if (hit_tri) begin
						st_nxt.rdat = {3'h0, st_r.tri_ctrl};
					end else if (hit_cal && gate_open) begin
						st_nxt.rdat = st_r.cal_code;
					end else if (hit_init) begin
						st_nxt.rdat = st_r.init_code;
					end else begin
						st_nxt.rdat = 8'h00;
					end
				end
			end
			BUS_ACK: begin
				// Write commits at the edge where the master samples ack
				st_nxt.phase = BUS_IDLE;
				st_nxt.ack   = 1'b0;
				if (req && wr_byte) begin
					if (hit_tri) begin
						// Reserved bits are not stored
						st_nxt.tri_ctrl = wb_dat_i[TRI_W-1:0];
					end
					if (hit_cal && gate_open) begin
						st_nxt.cal_code = wb_dat_i[7:0];
					end
					if (hit_init) begin
						st_nxt.init_code = wb_dat_i[7:0];
					end
				end
			end
			default: begin
				st_nxt.phase = BUS_IDLE;
				st_nxt.ack   = 1'b0;
			end
		endcase
		// Only the exact enable code runs calibration; writing the idle code
		// stops it again
		st_nxt.cal_on    = (st_nxt.cal_code == CAL_ENABLE_CODE);
		st_nxt.init_open = (st_nxt.init_code == INIT_OPEN_CODE);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r.phase     <= BUS_IDLE;
			st_r.ack       <= 1'b0;
			st_r.rdat      <= 8'h00;
			st_r.tri_ctrl  <= TRI_RESET;
			st_r.cal_code  <= CAL_RESET;
			st_r.init_code <= INIT_RESET;
			st_r.cal_on    <= 1'b0;
			st_r.init_open <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_ack_o       = st_r.ack;
	assign wb_dat_o       = {24'h000000, st_r.rdat};
	assign cal_circuit_en = st_r.cal_on;
	assign init_regs_open = st_r.init_open;

	// Keep bits feed the enable terms, gated by master_mode, overriding the global bit in master mode only
	assign pads.tristate_all = st_r.tri_ctrl[TRI_BIT_ALL];
	assign pads.keep         = st_r.tri_ctrl[3:0];
	assign pads.master_mode  = master_mode;
	assign pads.vsync_in     = vsync_src;
	assign pads.hsync_in     = hsync_src;
	assign pads.pclk_in      = pclk_src;
	assign pads.extsync_in   = extsync_src;
	assign pads.data_in      = data_src;

	// One register stage of latency from control write to pad enable
	pad_stage u_pad_stage (
		.sys_clk (sys_clk),
		.rst     (rst),
		.p       (pads)
	);

	assign vsync_out   = pads.vsync_q;
	assign vsync_oe    = pads.vsync_oe;
	assign hsync_out   = pads.hsync_q;
	assign hsync_oe    = pads.hsync_oe;
	assign pclk_out    = pads.pclk_q;
	assign pclk_oe     = pads.pclk_oe;
	assign extsync_out = pads.extsync_q;
	assign extsync_oe  = pads.extsync_oe;
	assign data_out    = pads.data_q;
	assign data_oe     = pads.data_oe;

endmodule : video_port_tristate_and_cal_gate

// >>> rtl/vidport_pkg.sv
// Constants and types shared by the video port control register bank
package vidport_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] REG_IDX_TRISTATE = 8'h55;
	localparam logic [7:0] REG_IDX_CAL      = 8'h80;
	localparam logic [7:0] REG_IDX_INIT     = 8'h88;

	// Field positions in video_output_tristate_ctrl
	localparam int TRI_BIT_ALL      = 4;
	localparam int TRI_BIT_VS_KEEP  = 3;
	localparam int TRI_BIT_HS_KEEP  = 2;
	localparam int TRI_BIT_PCK_KEEP = 1;
	localparam int TRI_BIT_EXT_KEEP = 0;
	localparam int TRI_W            = 5;

	// Values after reset
	localparam logic [TRI_W-1:0] TRI_RESET  = 5'h00;
	localparam logic [7:0]       CAL_RESET  = 8'h00;
	localparam logic [7:0]       INIT_RESET = 8'h00;

	// Codes of the calibration and initialization access fields
	localparam logic [7:0] CAL_ENABLE_CODE = 8'h05;
	localparam logic [7:0] CAL_IDLE_CODE   = 8'h00;
	localparam logic [7:0] INIT_OPEN_CODE  = 8'h01;
	localparam logic [7:0] INIT_SHUT_CODE  = 8'h00;

	// Video data width and bus widths
	localparam int DATA_W   = 10;
	localparam int WB_AW    = 10;
	localparam int WB_DW    = 32;
	localparam int WB_SW    = 4;

	// Bus slave phase
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_phase_t;

endpackage : vidport_pkg

// >>> rtl/pad_if.sv
// Carrier between the register bank and its output pad stage
`timescale 1ns/100ps
interface pad_if;
	import vidport_pkg::*;

	logic              tristate_all;
	logic [3:0]        keep;
	logic              master_mode;
	logic              vsync_in;
	logic              hsync_in;
	logic              pclk_in;
	logic              extsync_in;
	logic [DATA_W-1:0] data_in;
	logic              vsync_q;
	logic              vsync_oe;
	logic              hsync_q;
	logic              hsync_oe;
	logic              pclk_q;
	logic              pclk_oe;
	logic              extsync_q;
	logic              extsync_oe;
	logic [DATA_W-1:0] data_q;
	logic              data_oe;

	modport ctrl (
		output tristate_all, keep, master_mode,
		output vsync_in, hsync_in, pclk_in, extsync_in, data_in,
		input  vsync_q, vsync_oe, hsync_q, hsync_oe, pclk_q, pclk_oe,
		input  extsync_q, extsync_oe, data_q, data_oe
	);

	modport stage (
		input  tristate_all, keep, master_mode,
		input  vsync_in, hsync_in, pclk_in, extsync_in, data_in,
		output vsync_q, vsync_oe, hsync_q, hsync_oe, pclk_q, pclk_oe,
		output extsync_q, extsync_oe, data_q, data_oe
	);

endinterface : pad_if

// >>> rtl/pad_stage.sv
// Registered output stage of the digital video port with enable logic
`timescale 1ns/100ps
module pad_stage
	import vidport_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	pad_if.stage     p
);

	typedef struct packed {
		logic              vs;
		logic              vs_oe;
		logic              hs;
		logic              hs_oe;
		logic              pck;
		logic              pck_oe;
		logic              ext;
		logic              ext_oe;
		logic [DATA_W-1:0] dat;
		logic              dat_oe;
	} pad_state_t;

	pad_state_t st_r;
	pad_state_t st_nxt;

	always_comb begin
		st_nxt     = st_r;
		st_nxt.vs  = p.vsync_in;
		st_nxt.hs  = p.hsync_in;
		st_nxt.pck = p.pclk_in;
		st_nxt.ext = p.extsync_in;
		st_nxt.dat = p.data_in;
		// Data has no keep bit: it always follows the global control
		st_nxt.dat_oe = !p.tristate_all;
		// A keep bit only counts in master timing mode and wins over the global bit
		st_nxt.vs_oe  = !p.tristate_all | (p.master_mode & p.keep[TRI_BIT_VS_KEEP]);
		st_nxt.hs_oe  = !p.tristate_all | (p.master_mode & p.keep[TRI_BIT_HS_KEEP]);
		st_nxt.pck_oe = !p.tristate_all | (p.master_mode & p.keep[TRI_BIT_PCK_KEEP]);
		st_nxt.ext_oe = !p.tristate_all | (p.master_mode & p.keep[TRI_BIT_EXT_KEEP]);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '{vs_oe: 1'b1, hs_oe: 1'b1, pck_oe: 1'b1, ext_oe: 1'b1,
				dat_oe: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign p.vsync_q    = st_r.vs;
	assign p.vsync_oe   = st_r.vs_oe;
	assign p.hsync_q    = st_r.hs;
	assign p.hsync_oe   = st_r.hs_oe;
	assign p.pclk_q     = st_r.pck;
	assign p.pclk_oe    = st_r.pck_oe;
	assign p.extsync_q  = st_r.ext;
	assign p.extsync_oe = st_r.ext_oe;
	assign p.data_q     = st_r.dat;
	assign p.data_oe    = st_r.dat_oe;

endmodule : pad_stage

// >>> verif/vp_asserts.sv
// Concurrent checks on the video port control bank
`timescale 1ns/100ps
module vp_asserts
	import vidport_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [WB_AW-1:0]  wb_adr_i,
	input wire logic [WB_SW-1:0]  wb_sel_i,
	input wire logic [WB_DW-1:0]  wb_dat_i,
	input wire logic [WB_DW-1:0]  wb_dat_o,
	input wire logic              wb_ack_o,
	input wire logic              master_mode,
	input wire logic              vsync_oe,
	input wire logic              hsync_oe,
	input wire logic              pclk_oe,
	input wire logic              extsync_oe,
	input wire logic              data_oe,
	input wire logic              cal_circuit_en,
	input wire logic              init_regs_open
);
	logic [4:0] tri_r;
	logic [3:0] exp_r;
	wire        wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	wire  [7:0] wd = wb_dat_i[7:0];
	// Shadow of the control field, committed at the same ack edge as the bank
	always_ff @(posedge sys_clk) begin
		tri_r <= rst ? 5'h00 : (wr && wb_adr_i == 10'h154) ? wd[4:0] : tri_r;
		exp_r <= {4{master_mode}} & tri_r[3:0] | {4{!tri_r[4]}};
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence wr_cal; wr && wb_adr_i == 10'h200; endsequence
	sequence wr_init; wr && wb_adr_i == 10'h220; endsequence
	sequence rd_tri; wb_ack_o && !wb_we_i && wb_adr_i == 10'h154; endsequence
	ack_single_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer is not one cycle");
	data_tristate_a: assert property (data_oe == !$past(tri_r[4]))
		else $error("data enable wrong");
	vs_keep_a: assert property (vsync_oe == exp_r[3])
		else $error("vsync enable wrong");
	hs_keep_a: assert property (hsync_oe == exp_r[2])
		else $error("hsync enable wrong");
	pclk_keep_a: assert property (pclk_oe == exp_r[1])
		else $error("pixel clock enable wrong");
	ext_keep_a: assert property (extsync_oe == exp_r[0])
		else $error("external sync enable wrong");
	cal_code_a: assert property (wr_cal ##0 init_regs_open |=> cal_circuit_en == ($past(wd) == 8'h05))
		else $error("calibration enable wrong");
	cal_gate_a: assert property (wr_cal ##0 !init_regs_open |=> $stable(cal_circuit_en))
		else $error("closed calibration write took effect");
	init_open_a: assert property (wr_init |=> init_regs_open == ($past(wd) == 8'h01))
		else $error("init access state wrong");
	tri_read_a: assert property (rd_tri |-> wb_dat_o == {27'h0, tri_r})
		else $error("control read back wrong");
endmodule : vp_asserts

// >>> verif/vp_capture.sv
// Capture side model: sees the port pins as a receiver would
`timescale 1ns/100ps
module vp_capture (
	input  wire logic        sys_clk,
	input  wire logic [13:0] pad_q,
	input  wire logic [13:0] pad_oe,
	output logic      [13:0] seen
);
	logic [13:0] last_r;
	always_ff @(posedge sys_clk) last_r <= seen;
	// No pull on the pins: a released pin toggles so a stale value never matches
	always_comb for (int i = 0; i < 14; i++) seen[i] = pad_oe[i] ? pad_q[i] : ~last_r[i];
endmodule : vp_capture

// >>> verif/video_port_tristate_and_cal_gate_tb.sv
// Self-checking bench of the video port control bank
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module video_port_tristate_and_cal_gate_tb;
	import vidport_pkg::*;
	logic sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, master_mode = 0;
	logic vsync_src = 0, hsync_src = 0, pclk_src = 0, extsync_src = 0;
	logic [WB_AW-1:0]  wb_adr_i = '0;
	logic [WB_SW-1:0]  wb_sel_i = '0;
	logic [WB_DW-1:0]  wb_dat_i = '0, wb_dat_o, q;
	logic [DATA_W-1:0] data_src = '0, data_out;
	logic wb_ack_o, vsync_out, vsync_oe, hsync_out, hsync_oe, pclk_out, pclk_oe;
	logic extsync_out, extsync_oe, data_oe, cal_circuit_en, init_regs_open;
	logic [13:0] seen;
	logic [31:0] x = 32'h8dee;
	logic [3:0]  sel_v = 4'h1;
	logic [7:0]  codes [4] = '{8'h05, 8'h07, 8'h05, 8'h00};
	int err_total = 0, check_count = 0, n_clk = 0, tri_m = 0, cal_m = 0, init_m = 0;
	video_port_tristate_and_cal_gate i_dut (.*);
	vp_capture i_cap (.sys_clk(sys_clk), .seen(seen),
		.pad_q({vsync_out, hsync_out, pclk_out, extsync_out, data_out}),
		.pad_oe({vsync_oe, hsync_oe, pclk_oe, extsync_oe, {10{data_oe}}}));
	function automatic logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd
	function automatic int mdl(input logic [9:0] a);
		case (a)
			10'h154: return tri_m;
			10'h200: return init_m == 1 ? cal_m : 0;
			10'h220: return init_m;
			default: return 0;
		endcase
	endfunction : mdl
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= sel_v;
		wb_dat_i <= {24'h0, d};
		// A missing ack is ended by the bench timeout alone
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
		if (w && sel_v[0] && a == 10'h154) tri_m = d & 8'h1f;
		if (w && sel_v[0] && a == 10'h200 && init_m == 1) cal_m = d;
		if (w && sel_v[0] && a == 10'h220) init_m = d;
	endtask : bus
	task automatic rd(input logic [9:0] a);
		bus(1'b0, a, 8'h00);
		`CHK(q, 32'(mdl(a)))
	endtask : rd
	task automatic pads();
		int k;
		k = tri_m[4] ? 0 : 15;
		if (master_mode) k = k | (tri_m & 15);
		`CHK({vsync_oe, hsync_oe, pclk_oe, extsync_oe}, 4'(k))
		`CHK(data_oe, !tri_m[4])
		`CHK(seen[13:10] & 4'(k), {vsync_src, hsync_src, pclk_src, extsync_src} & 4'(k))
		if (!tri_m[4]) `CHK(seen[9:0], data_src)
		`CHK(cal_circuit_en, cal_m == 5)
		`CHK(init_regs_open, init_m == 1)
	endtask : pads
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	always #2.5 sys_clk = ~sys_clk;
	// Whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		n_clk++;
		if (n_clk == 5000) begin err_total++; results(); end
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(10'h154);
		rd(10'h200);
		rd(10'h220);
		pads();
		$display("reset test done");
		for (int i = 0; i < 24; i++) begin
			bus(1'b1, 10'h154, 8'(rnd()));
			master_mode <= 1'(rnd());
			{vsync_src, hsync_src, pclk_src, extsync_src, data_src} <= 14'(rnd());
			repeat (2) @(posedge sys_clk);
			pads();
			rd(10'h154);
		end
		bus(1'b1, 10'h158, 8'hff);
		rd(10'h158);
		// Low byte lane off: the write must be ignored
		sel_v = 4'he;
		bus(1'b1, 10'h154, 8'h10);
		sel_v = 4'h1;
		rd(10'h154);
		$display("tristate test done");
		bus(1'b1, 10'h200, 8'h05);
		rd(10'h200);
		pads();
		bus(1'b1, 10'h220, 8'h01);
		foreach (codes[j]) begin
			bus(1'b1, 10'h200, codes[j]);
			pads();
			rd(10'h200);
		end
		bus(1'b1, 10'h220, 8'h00);
		bus(1'b1, 10'h200, 8'h05);
		pads();
		rd(10'h220);
		$display("calibration test done");
		bus(1'b1, 10'h154, 8'h1f);
		bus(1'b1, 10'h220, 8'h01);
		bus(1'b1, 10'h200, 8'h05);
		pads();
		@(posedge sys_clk);
		// Two reset edges so the checker shadow settles before it is enabled again
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		tri_m = 0;
		cal_m = 0;
		init_m = 0;
		@(posedge sys_clk);
		rd(10'h154);
		rd(10'h220);
		pads();
		$display("mid-run reset test done");
		results();
	end
endmodule : video_port_tristate_and_cal_gate_tb
bind video_port_tristate_and_cal_gate vp_asserts i_chk (.*);
